// file: iopfm_pkg.sv
// Package for the IO pin function mux: register map, field layout, reset values.
// Assumes a 32-bit APB slave port and 3-bit function selects per pin.
package iopfm_pkg;
    localparam int          IOPFM_FLD_W     = 3;
    localparam int          IOPFM_FLD_STEP  = 4;
    localparam int          IOPFM_NGRP      = 8;
    localparam int          IOPFM_XBAR_W    = 6;
    localparam int          IOPFM_NUP       = 8;
    localparam int          IOPFM_NFLASH    = 5;
    localparam int          IOPFM_NLP       = IOPFM_NUP + 1;
    localparam int          IOPFM_NPIN      = IOPFM_NLP + IOPFM_NFLASH;
    localparam int          IOPFM_IDX_LAST  = IOPFM_NUP;
    localparam int          IOPFM_IDX_FLASH = IOPFM_NLP;
    localparam logic [31:0] IOPFM_ADDR_UP   = 32'h4000_b04c;
    localparam logic [31:0] IOPFM_ADDR_FL   = 32'h4000_b068;
    localparam logic [31:0] IOPFM_ADDR_LAST = 32'h4000_b080;
    localparam logic [2:0]  IOPFM_SEL_RST   = 3'h0;
    localparam logic [2:0]  IOPFM_SEL_XBAR  = 3'h1;
    localparam logic [5:0]  IOPFM_XBAR_IDLE = 6'h3f;
    localparam logic [31:0] IOPFM_ZERO32    = 32'h0000_0000;

    // One peripheral function's drive toward a pin
    typedef struct packed {
        logic out;
        logic oe;
    } iopfm_drive_s;
endpackage : iopfm_pkg

// file: iopfm_pin_slice.sv
// One pin's function mux: 8-way output select, input routing, crossbar hand-off.
// Assumes pad_in is asynchronous to clock; all outputs are registered.
`timescale 1ns/1ps
module iopfm_pin_slice
    import iopfm_pkg::*;
#(
    parameter int NGRP = IOPFM_NGRP
) (
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire logic [IOPFM_FLD_W-1:0]  sel,
    input  wire iopfm_drive_s [NGRP-1:0] drv,
    input  wire logic                    pad_in,
    input  wire logic [IOPFM_XBAR_W-1:0] xbar_pick,
    output logic                         pad_out,
    output logic                         pad_oe,
    output logic [NGRP-1:0]              grp_in,
    output logic                         xbar_on,
    output logic [IOPFM_XBAR_W-1:0]      xbar_apply
);
    if (NGRP != (1 << IOPFM_FLD_W)) begin : g_chk
        $error("NGRP must equal the number of select codes");
    end

    logic sync1_r;
    logic sync2_r;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pad_in;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pad_out <= 1'b0;
            pad_oe  <= 1'b0;
        end else begin
            pad_out <= drv[sel].out;
            pad_oe  <= drv[sel].oe;
        end
    end

    // Unselected groups see a quiet zero rather than the pad
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            grp_in <= '0;
        end else begin
            for (int g = 0; g < NGRP; g++) begin
                grp_in[g] <= sync2_r && (sel == g[IOPFM_FLD_W-1:0]);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            xbar_on    <= 1'b0;
            xbar_apply <= IOPFM_XBAR_IDLE;
        end else begin
            xbar_on    <= (sel == IOPFM_SEL_XBAR);
            xbar_apply <= (sel == IOPFM_SEL_XBAR) ? xbar_pick : IOPFM_XBAR_IDLE;
        end
    end
endmodule : iopfm_pin_slice

// file: iopfm_top.sv
// IO pin function mux: APB registers holding 3-bit selects for low-power
// pins 16..24 and internal flash pins 0..4, plus one mux slice per pin.
// Assumes an APB master on clock; crossbar selects come from elsewhere.
`timescale 1ns/1ps
// Function
// - Pins 16..23 each own a 3-bit select, pin 23 topmost, 16 lowest.
// - Select value n routes peripheral function group n to the pin.
// - Select value one hands a low-power pin to the wide crossbar.
// - Crossbar pick applies only while select is one; idle value all ones.
// - Five 3-bit selects for flash pins 4..0, pin 4 topmost.
// - Pin 24 has one 3-bit select in the low bits of its own register.
// - Reset clears every select to zero.
module iopfm_top
    import iopfm_pkg::*;
(
    input  wire logic                                    clock,
    input  wire logic                                    rst_n,
    input  wire logic                                    psel,
    input  wire logic                                    penable,
    input  wire logic                                    pwrite,
    input  wire logic [31:0]                             paddr,
    input  wire logic [31:0]                             pwdata,
    input  wire logic [3:0]                              pstrb,
    output logic [31:0]                                  prdata,
    output logic                                         pready,
    output logic                                         pslverr,
    input  wire logic [IOPFM_NLP-1:0]                    lp_pad_in,
    output logic [IOPFM_NLP-1:0]                         lp_pad_out,
    output logic [IOPFM_NLP-1:0]                         lp_pad_oe,
    input  wire logic [IOPFM_NFLASH-1:0]                 fl_pad_in,
    output logic [IOPFM_NFLASH-1:0]                      fl_pad_out,
    output logic [IOPFM_NFLASH-1:0]                      fl_pad_oe,
    input  wire iopfm_drive_s [IOPFM_NPIN-1:0][IOPFM_NGRP-1:0] grp_drv,
    output logic [IOPFM_NPIN-1:0][IOPFM_NGRP-1:0]        grp_in,
    input  wire logic [IOPFM_NLP-1:0][IOPFM_XBAR_W-1:0]  xbar_pick,
    output logic [IOPFM_NLP-1:0][IOPFM_XBAR_W-1:0]       xbar_apply,
    output logic [IOPFM_NLP-1:0]                         xbar_on
);
    logic [IOPFM_NPIN-1:0][IOPFM_FLD_W-1:0] sel_r;
    logic [31:0]                            rd_nxt;
    logic                                   hit_up;
    logic                                   hit_fl;
    logic                                   hit_last;
    logic                                   wr_en;
    logic [IOPFM_NPIN-1:0]                  pad_in_all;
    logic [IOPFM_NPIN-1:0]                  pad_out_all;
    logic [IOPFM_NPIN-1:0]                  pad_oe_all;

    assign hit_up   = (paddr == IOPFM_ADDR_UP);
    assign hit_fl   = (paddr == IOPFM_ADDR_FL);
    assign hit_last = (paddr == IOPFM_ADDR_LAST);
    // Zero wait states: read data is captured in the setup cycle
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !(hit_up || hit_fl || hit_last);
    assign wr_en    = psel && penable && pwrite;

    // A write to field i lands only when the byte lane carrying it is strobed
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sel_r <= {IOPFM_NPIN{IOPFM_SEL_RST}};
        end else if (wr_en) begin
            for (int i = 0; i < IOPFM_NUP; i++) begin
                if (hit_up && pstrb[i/2]) begin
                    sel_r[i] <= pwdata[i*IOPFM_FLD_STEP +: IOPFM_FLD_W];
                end
            end
            for (int i = 0; i < IOPFM_NFLASH; i++) begin
                if (hit_fl && pstrb[i/2]) begin
                    sel_r[IOPFM_IDX_FLASH+i] <= pwdata[i*IOPFM_FLD_STEP +: IOPFM_FLD_W];
                end
            end
            if (hit_last && pstrb[0]) begin
                sel_r[IOPFM_IDX_LAST] <= pwdata[IOPFM_FLD_W-1:0];
            end
        end
    end

    always_comb begin
        rd_nxt = IOPFM_ZERO32;
        if (hit_up) begin
            for (int i = 0; i < IOPFM_NUP; i++) begin
                rd_nxt[i*IOPFM_FLD_STEP +: IOPFM_FLD_W] = sel_r[i];
            end
        end else if (hit_fl) begin
            for (int i = 0; i < IOPFM_NFLASH; i++) begin
                rd_nxt[i*IOPFM_FLD_STEP +: IOPFM_FLD_W] = sel_r[IOPFM_IDX_FLASH+i];
            end
        end else if (hit_last) begin
            rd_nxt[IOPFM_FLD_W-1:0] = sel_r[IOPFM_IDX_LAST];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata <= IOPFM_ZERO32;
        end else if (psel && !penable) begin
            prdata <= rd_nxt;
        end
    end

    assign pad_in_all = {fl_pad_in, lp_pad_in};
    assign lp_pad_out = pad_out_all[IOPFM_NLP-1:0];
    assign lp_pad_oe  = pad_oe_all[IOPFM_NLP-1:0];
    assign fl_pad_out = pad_out_all[IOPFM_NPIN-1:IOPFM_NLP];
    assign fl_pad_oe  = pad_oe_all[IOPFM_NPIN-1:IOPFM_NLP];

    for (genvar p = 0; p < IOPFM_NPIN; p++) begin : g_pin
        if (p < IOPFM_NLP) begin : g_lp
            iopfm_pin_slice #(.NGRP(IOPFM_NGRP)) u_slice (
                .clock      (clock),
                .rst_n      (rst_n),
                .sel        (sel_r[p]),
                .drv        (grp_drv[p]),
                .pad_in     (pad_in_all[p]),
                .xbar_pick  (xbar_pick[p]),
                .pad_out    (pad_out_all[p]),
                .pad_oe     (pad_oe_all[p]),
                .grp_in     (grp_in[p]),
                .xbar_on    (xbar_on[p]),
                .xbar_apply (xbar_apply[p])
            );
        end else begin : g_fl
            // Flash pins have no crossbar behind them
            iopfm_pin_slice #(.NGRP(IOPFM_NGRP)) u_slice (
                .clock      (clock),
                .rst_n      (rst_n),
                .sel        (sel_r[p]),
                .drv        (grp_drv[p]),
                .pad_in     (pad_in_all[p]),
                .xbar_pick  (IOPFM_XBAR_IDLE),
                .pad_out    (pad_out_all[p]),
                .pad_oe     (pad_oe_all[p]),
                .grp_in     (grp_in[p]),
                .xbar_on    (),
                .xbar_apply ()
            );
        end
    end

    // Helper state for the checks below
    logic [31:0]                        pw_q;
    logic                               exp_out0;
    logic                               exp_oe13;
    always_ff @(posedge clock) begin
        pw_q <= pwdata;
    end
    assign exp_out0 = grp_drv[0][sel_r[0]].out;
    assign exp_oe13 = grp_drv[IOPFM_NPIN-1][sel_r[IOPFM_NPIN-1]].oe;

    property p_up_read;
        @(posedge clock) disable iff (!rst_n)
        psel && penable && !pwrite && hit_up |->
            prdata[30:28] == sel_r[7] && prdata[2:0] == sel_r[0];
    endproperty
    a_up_read: assert property (p_up_read) else $error("upper select readback wrong");

    property p_route;
        @(posedge clock) disable iff (!rst_n)
        1'b1 |=> lp_pad_out[0] == $past(exp_out0) && fl_pad_oe[4] == $past(exp_oe13);
    endproperty
    a_route: assert property (p_route) else $error("pad not driven by selected group");

    property p_xbar_on;
        @(posedge clock) disable iff (!rst_n)
        sel_r[3] == IOPFM_SEL_XBAR |=> xbar_on[3];
    endproperty
    a_xbar_on: assert property (p_xbar_on) else $error("crossbar hand-off missing");

    property p_xbar_gate;
        @(posedge clock) disable iff (!rst_n)
        sel_r[2] != IOPFM_SEL_XBAR |=> !xbar_on[2] && xbar_apply[2] == IOPFM_XBAR_IDLE;
    endproperty
    a_xbar_gate: assert property (p_xbar_gate) else $error("crossbar applied off code one");

    property p_fl_write;
        @(posedge clock) disable iff (!rst_n)
        wr_en && hit_fl && pstrb == 4'hf |=>
            sel_r[IOPFM_IDX_FLASH] == pw_q[2:0] && sel_r[IOPFM_NPIN-1] == pw_q[18:16];
    endproperty
    a_fl_write: assert property (p_fl_write) else $error("flash select write lost");

    property p_last_write;
        @(posedge clock) disable iff (!rst_n)
        wr_en && hit_last && pstrb[0] |=> sel_r[IOPFM_IDX_LAST] == pw_q[2:0];
    endproperty
    a_last_write: assert property (p_last_write) else $error("pin 24 select write lost");

    property p_reset;
        @(posedge clock) !rst_n |=> sel_r == '0 && !xbar_on[0];
    endproperty
    a_reset: assert property (p_reset) else $error("selects not cleared by reset");

    property p_unused_zero;
        @(posedge clock) disable iff (!rst_n)
        psel && penable && !pwrite && hit_last |-> prdata[31:3] == '0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");

    // A partial write must not clobber fields in lanes that were not strobed
    property p_lane_hold;
        @(posedge clock) disable iff (!rst_n)
        wr_en && hit_up && !pstrb[3] |=> $stable(sel_r[IOPFM_NUP-1]);
    endproperty
    a_lane_hold: assert property (p_lane_hold) else $error("unstrobed select changed");

    property p_grp_quiet;
        @(posedge clock) disable iff (!rst_n)
        1'b1 |=> (grp_in[0] & ~(8'h01 << $past(sel_r[0]))) == 8'h00;
    endproperty
    a_grp_quiet: assert property (p_grp_quiet) else $error("group input leaks");

    property p_fl_read;
        @(posedge clock) disable iff (!rst_n)
        psel && penable && !pwrite && hit_fl |->
            prdata[18:16] == sel_r[IOPFM_NPIN-1] && prdata[2:0] == sel_r[IOPFM_IDX_FLASH];
    endproperty
    a_fl_read: assert property (p_fl_read) else $error("flash select readback wrong");

    property p_up_unused;
        @(posedge clock) disable iff (!rst_n)
        psel && penable && !pwrite && hit_up |-> (prdata & ~32'h7777_7777) == 32'h0000_0000;
    endproperty
    a_up_unused: assert property (p_up_unused) else $error("gap bits not zero");
endmodule : iopfm_top

// file: iopfm_periph_model.sv
// Peripheral side of the pin mux: function group drives, pad levels, crossbar picks.
// Assumes the bench sets pad levels; drives churn on every rising clock edge.
`timescale 1ns/1ps
module iopfm_periph_model
    import iopfm_pkg::*;
(
    input  wire logic                                     clock,
    input  wire logic [IOPFM_NPIN-1:0]                    pads_set,
    output iopfm_drive_s [IOPFM_NPIN-1:0][IOPFM_NGRP-1:0] grp_drv,
    output logic [IOPFM_NLP-1:0]                          lp_pad_in,
    output logic [IOPFM_NFLASH-1:0]                       fl_pad_in,
    output logic [IOPFM_NLP-1:0][IOPFM_XBAR_W-1:0]        xbar_pick
);
    int seed = 5;
    assign lp_pad_in = pads_set[IOPFM_NLP-1:0];
    assign fl_pad_in = pads_set[IOPFM_NPIN-1:IOPFM_NLP];
    initial begin
        grp_drv = '0;
        xbar_pick = '0;
    end
    // New drives every cycle, so a stale or wrong mux leg cannot match by luck
    always @(posedge clock) begin
        grp_drv <= {$random(seed), $random(seed), $random(seed), $random(seed),
                    $random(seed), $random(seed), $random(seed)};
    end
    always @(pads_set) begin
        xbar_pick <= 54'({$random(seed), $random(seed)});
    end
endmodule : iopfm_periph_model

// file: iopfm_top_tb_top.sv
// Self-checking bench for the pin function mux: APB master, read scoreboard, pad checks.
// Assumes zero or more APB wait states; peripheral model on the far side.
`timescale 1ns/1ps
module iopfm_top_tb_top;
    import iopfm_pkg::*;
    logic        clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [31:0] paddr = '0, pwdata = '0, prdata;
    logic [3:0]  pstrb = '0;
    logic [IOPFM_NPIN-1:0] pads_set = '0;
    logic [IOPFM_NLP-1:0]  lp_pad_in, lp_pad_out, lp_pad_oe, xbar_on;
    logic [IOPFM_NFLASH-1:0] fl_pad_in, fl_pad_out, fl_pad_oe;
    iopfm_drive_s [IOPFM_NPIN-1:0][IOPFM_NGRP-1:0] grp_drv, prev_drv;
    logic [IOPFM_NPIN-1:0][IOPFM_NGRP-1:0]         grp_in;
    logic [IOPFM_NLP-1:0][IOPFM_XBAR_W-1:0]        xbar_pick, xbar_apply;
    logic [2:0]  sel [IOPFM_NPIN];
    logic [32:0] exp_q [$];
    int          n_errors = 0, compares = 0, seed = 99, n, p;
    always #12.5 clock = ~clock;
    always @(posedge clock) prev_drv <= grp_drv;
    iopfm_periph_model u_iopfm_periph_model (.clock(clock), .pads_set(pads_set),
        .grp_drv(grp_drv), .lp_pad_in(lp_pad_in), .fl_pad_in(fl_pad_in), .xbar_pick(xbar_pick));
    iopfm_top u_iopfm_top (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lp_pad_in(lp_pad_in), .lp_pad_out(lp_pad_out),
        .lp_pad_oe(lp_pad_oe), .fl_pad_in(fl_pad_in), .fl_pad_out(fl_pad_out),
        .fl_pad_oe(fl_pad_oe), .grp_drv(grp_drv), .grp_in(grp_in), .xbar_pick(xbar_pick),
        .xbar_apply(xbar_apply), .xbar_on(xbar_on));
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        compares++;
        if (seen !== want) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic conclude();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    // Reads are judged at the edge that completes them, oldest note first
    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check({pslverr, prdata}, exp_q.pop_front());
        end
    end
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (pready !== 1'b1 && i < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never re-drives psel in this time step
        @(posedge clock);
        if (i >= 20) begin
            n_errors++;
            conclude();
        end
    endtask : apb
    task automatic rd(input logic [31:0] a, input logic [32:0] want);
        exp_q.push_back(want);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
    endtask : rd
    task automatic check_pins();
        int q;
        repeat (3) @(posedge clock);
        #1;
        for (q = 0; q < IOPFM_NPIN; q++) begin
            if (q < IOPFM_NLP) begin
                check(33'({lp_pad_out[q], lp_pad_oe[q]}), 33'(prev_drv[q][sel[q]]));
                check(33'({xbar_on[q], xbar_apply[q]}), (sel[q] == IOPFM_SEL_XBAR) ?
                      33'({1'b1, xbar_pick[q]}) : 33'({1'b0, IOPFM_XBAR_IDLE}));
            end else begin
                check(33'({fl_pad_out[q-IOPFM_NLP], fl_pad_oe[q-IOPFM_NLP]}),
                      33'(prev_drv[q][sel[q]]));
            end
            check(33'(grp_in[q]), 33'(8'(pads_set[q]) << sel[q]));
        end
    endtask : check_pins
    // Writes every select from the sel table, reads each register back, checks pads
    task automatic program_all();
        logic [31:0] up, fl;
        int q;
        up = '0;
        fl = '0;
        for (q = 0; q < IOPFM_NUP; q++) up |= 32'(sel[q]) << (4 * q);
        for (q = 0; q < IOPFM_NFLASH; q++) fl |= 32'(sel[IOPFM_IDX_FLASH + q]) << (4 * q);
        apb(1'b1, IOPFM_ADDR_UP, up, 4'hf);
        apb(1'b1, IOPFM_ADDR_FL, fl, 4'hf);
        apb(1'b1, IOPFM_ADDR_LAST, 32'(sel[IOPFM_IDX_LAST]), 4'hf);
        rd(IOPFM_ADDR_UP, {1'b0, up});
        rd(IOPFM_ADDR_FL, {1'b0, fl});
        rd(IOPFM_ADDR_LAST, {1'b0, 32'(sel[IOPFM_IDX_LAST])});
        check_pins();
    endtask : program_all
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        for (p = 0; p < IOPFM_NPIN; p++) sel[p] = IOPFM_SEL_RST;
        rd(IOPFM_ADDR_UP, 33'h0_0000_0000);
        rd(IOPFM_ADDR_FL, 33'h0_0000_0000);
        rd(IOPFM_ADDR_LAST, 33'h0_0000_0000);
        check_pins();
        // Every code reaches every pin, and neighbouring pins never share a code
        for (n = 0; n < IOPFM_NGRP; n++) begin
            for (p = 0; p < IOPFM_NPIN; p++) sel[p] = 3'((n + p) % IOPFM_NGRP);
            pads_set <= 14'($random(seed));
            program_all();
        end
        apb(1'b1, IOPFM_ADDR_UP, 32'hffff_ffff, 4'hf);
        apb(1'b1, IOPFM_ADDR_FL, 32'hffff_ffff, 4'hf);
        apb(1'b1, IOPFM_ADDR_LAST, 32'hffff_ffff, 4'hf);
        rd(IOPFM_ADDR_UP, 33'h0_7777_7777);
        rd(IOPFM_ADDR_FL, 33'h0_0007_7777);
        rd(IOPFM_ADDR_LAST, 33'h0_0000_0007);
        apb(1'b1, IOPFM_ADDR_UP, 32'h0000_0000, 4'b0001);
        rd(IOPFM_ADDR_UP, 33'h0_7777_7700);
        rd(IOPFM_ADDR_UP + 32'h0000_0004, 33'h1_0000_0000);
        // Random codes for the low-power pins, a fixed pattern of codes for the flash pins
        for (p = 0; p < IOPFM_NLP; p++) sel[p] = 3'($random(seed));
        sel[9] = 3'h1;
        sel[10] = 3'h3;
        sel[11] = 3'h2;
        sel[12] = 3'h4;
        sel[13] = 3'h0;
        pads_set <= 14'($random(seed));
        program_all();
        conclude();
    end
endmodule : iopfm_top_tb_top
